// *** core/fct_classify.sv ***
`timescale 1ns/1ps
module fct_classify
(
   input wire fct_pkg::fct_fmt_type fmt,
   input wire logic [95:0] data,
   output logic neg,
   output logic zero,
   output logic inf,
   output logic nan_code_bit,
   output logic signan
);
   // Widening to extended never changes the class, so each format is classed in place.
   logic sign;

   always_comb
   begin
      sign = 1'b0;
      zero = 1'b0;
      inf = 1'b0;
      nan_code_bit = 1'b0;
      signan = 1'b0;
      case (fmt)
         fct_pkg::FMT_B:
         begin
            sign = data[7];
            zero = data[7:0] == 8'h00;
         end
         fct_pkg::FMT_W:
         begin
            sign = data[15];
            zero = data[15:0] == 16'h0000;
         end
         fct_pkg::FMT_L:
         begin
            sign = data[31];
            zero = data[31:0] == 32'h0000_0000;
         end
         fct_pkg::FMT_S:
         begin
            sign = data[31];
            nan_code_bit = (data[30:23] == 8'hff) && (data[22:0] != 23'h0);
            inf = (data[30:23] == 8'hff) && (data[22:0] == 23'h0);
            signan = nan_code_bit && !data[22];
            zero = data[30:0] == 31'h0;
         end
         fct_pkg::FMT_D:
         begin
            sign = data[63];
            nan_code_bit = (data[62:52] == 11'h7ff) && (data[51:0] != 52'h0);
            inf = (data[62:52] == 11'h7ff) && (data[51:0] == 52'h0);
            signan = nan_code_bit && !data[51];
            zero = data[62:0] == 63'h0;
         end
         fct_pkg::FMT_X:
         begin
            sign = data[95];
            nan_code_bit = (data[94:80] == 15'h7fff) && (data[62:0] != 63'h0);
            inf = (data[94:80] == 15'h7fff) && (data[62:0] == 63'h0);
            signan = nan_code_bit && !data[62];
            zero = (data[94:80] == 15'h0) && (data[63:0] == 64'h0);
         end
         default:
         begin
            sign = 1'b0;
         end
      endcase
      neg = sign && !nan_code_bit;
   end
endmodule : fct_classify

// *** core/fct_decoder.sv ***
`timescale 1ns/1ps
module fct_decoder #(
   parameter logic [7:0] TRAP_VECTOR = 8'h20,
   parameter logic [7:0] UNORD_VECTOR = 8'h21,
   parameter logic [7:0] UNIMP_VECTOR = 8'h22
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic exc_req,
   output logic exc_pre,
   output logic [7:0] exc_vector
);
   fct_pkg::fct_state_type state;
   fct_pkg::fct_fmt_type fmt_q, src_fmt;
   logic [15:0] word0;
   logic [3:0] ctrl;
   logic [31:0] iaddr, status, next_status, next_pc, rd_mux;
   logic [7:0] result;
   logic [2:0] ext_left, ext_total, need;
   logic [4:0] pred_q;
   logic [95:0] opnd;
   logic test_q, wr_take, start, ext_take, sts_wr, exec_trap, exec_test;
   logic is_trap, is_test, id_ok, rm, ea_ok, unimp, accept, cond_true, nonaware;
   logic unord_set, unord_trap, c_neg, c_zero, c_inf, c_nan, c_signan;

   assign wr_take = avs_write && !avs_waitrequest;
   assign start = wr_take && (avs_address == fct_pkg::OFF_WORD1) && (state == fct_pkg::ST_IDLE);
   assign ext_take = wr_take && (avs_address == fct_pkg::OFF_EXT) && (state == fct_pkg::ST_COLLECT);
   assign sts_wr = wr_take && (avs_address == fct_pkg::OFF_STATUS);
   assign exec_trap = (state == fct_pkg::ST_EXEC) && !test_q;
   assign exec_test = (state == fct_pkg::ST_EXEC) && test_q;

   fct_pred_eval u_pred
   (
      .pred(pred_q),
      .code_n(status[fct_pkg::COND_N]),
      .code_z(status[fct_pkg::COND_Z]),
      .code_nan(status[fct_pkg::COND_NAN]),
      .cond_true(cond_true),
      .nonaware(nonaware)
   );

   fct_classify u_class
   (
      .fmt(fmt_q),
      .data(opnd),
      .neg(c_neg),
      .zero(c_zero),
      .inf(c_inf),
      .nan_code_bit(c_nan),
      .signan(c_signan)
   );

   assign unord_set = status[fct_pkg::COND_NAN] && nonaware;
   assign unord_trap = unord_set && ctrl[fct_pkg::CTRL_UNORD_EN];

   // Every access gets exactly one wait cycle, which also gives read data a register stage.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
   end

   always_comb
   begin
      case (avs_address)
         fct_pkg::OFF_WORD0: rd_mux = {16'h0000, word0};
         fct_pkg::OFF_STATUS: rd_mux = status;
         fct_pkg::OFF_CTRL: rd_mux = {28'h0000000, ctrl};
         fct_pkg::OFF_RESULT: rd_mux = {16'h0000, exc_vector, result};
         fct_pkg::OFF_IADDR: rd_mux = iaddr;
         fct_pkg::OFF_NEXTPC: rd_mux = next_pc;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read && avs_waitrequest)
         avs_readdata <= rd_mux;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         word0 <= 16'h0000;
         ctrl <= fct_pkg::CTRL_RESET;
         iaddr <= 32'h0000_0000;
      end
      else if (wr_take)
      begin
         if (avs_address == fct_pkg::OFF_WORD0 && state == fct_pkg::ST_IDLE)
            word0 <= avs_writedata[15:0];
         if (avs_address == fct_pkg::OFF_CTRL)
            ctrl <= avs_writedata[3:0];
         if (avs_address == fct_pkg::OFF_IADDR)
            iaddr <= avs_writedata;
      end
   end

   // Decode looks at the stored first word and the second word as it is being written.
   always_comb
   begin
      id_ok = word0[11:9] == ctrl[2:0];
      is_trap = (word0[15:12] == fct_pkg::OP_LINE) && (word0[8:6] == fct_pkg::TRAP_TYPE)
         && (word0[5:3] == fct_pkg::TRAP_EA)
         && ((word0[2:0] == fct_pkg::TMODE_WORD) || (word0[2:0] == fct_pkg::TMODE_LONG)
         || (word0[2:0] == fct_pkg::TMODE_NONE));
      // The destination field is deliberately not examined.
      is_test = (word0[15:12] == fct_pkg::OP_LINE) && (word0[8:6] == fct_pkg::GEN_TYPE)
         && !avs_writedata[15] && !avs_writedata[13] && (avs_writedata[6:0] == fct_pkg::TEST_OPMODE);
      rm = avs_writedata[14];
      src_fmt = rm ? fct_pkg::fct_fmt_type'(avs_writedata[12:10]) : fct_pkg::FMT_X;
      unimp = is_test && rm && (src_fmt == fct_pkg::FMT_P);
      if (rm)
         ea_ok = fct_pkg::fct_ea_legal(word0[5:3], word0[2:0], src_fmt);
      else
         ea_ok = word0[5:0] == 6'h00;
      if (!is_trap)
         need = fct_pkg::fct_fmt_words(src_fmt);
      else if (word0[2:0] == fct_pkg::TMODE_LONG)
         need = 3'h2;
      else if (word0[2:0] == fct_pkg::TMODE_WORD)
         need = 3'h1;
      else
         need = 3'h0;
      accept = id_ok && (is_trap || (is_test && ea_ok && !unimp));
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= fct_pkg::ST_IDLE;
      else
      begin
         case (state)
            fct_pkg::ST_IDLE:
               if (start && accept)
                  state <= (need == 3'h0) ? fct_pkg::ST_EXEC : fct_pkg::ST_COLLECT;
            fct_pkg::ST_COLLECT:
               if (ext_take && ext_left == 3'h1)
                  state <= fct_pkg::ST_EXEC;
            fct_pkg::ST_EXEC:
               state <= fct_pkg::ST_IDLE;
            default:
               state <= fct_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         test_q <= 1'b0;
         fmt_q <= fct_pkg::FMT_X;
         pred_q <= 5'h00;
         ext_left <= 3'h0;
         ext_total <= 3'h0;
      end
      else if (start)
      begin
         test_q <= is_test;
         fmt_q <= src_fmt;
         pred_q <= avs_writedata[4:0];
         ext_left <= need;
         ext_total <= need;
      end
      else if (ext_take)
         ext_left <= ext_left - 3'h1;
   end

   // Trap immediates are counted off but never stored, so they cannot disturb the operand.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         opnd <= 96'h0;
      else if (start)
         opnd <= 96'h0;
      else if (ext_take && test_q)
         opnd <= {opnd[79:0], avs_writedata[15:0]};
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         next_pc <= 32'h0000_0000;
      else if (exec_trap)
         next_pc <= iaddr + 32'h0000_0004 + {28'h0000000, ext_total, 1'b0};
   end

   // A software write lands first and the instruction's own effect on top, so a set never gets lost.
   always_comb
   begin
      next_status = sts_wr ? avs_writedata : status;
      if (exec_trap && unord_set)
      begin
         next_status[fct_pkg::EXC_UNORD] = 1'b1;
         next_status[fct_pkg::ACC_INVALID] = 1'b1;
      end
      if (exec_test)
      begin
         next_status[fct_pkg::COND_N] = c_neg;
         next_status[fct_pkg::COND_Z] = c_zero;
         next_status[fct_pkg::COND_I] = c_inf;
         next_status[fct_pkg::COND_NAN] = c_nan;
         next_status[fct_pkg::EXC_SIGNAN] = c_signan;
         if (c_signan)
            next_status[fct_pkg::ACC_INVALID] = 1'b1;
         next_status[fct_pkg::EXC_UNORD] = 1'b0;
         next_status[fct_pkg::EXC_OPERAND:fct_pkg::EXC_INEXACT] = 5'h00;
         if (fmt_q != fct_pkg::FMT_P)
            next_status[fct_pkg::EXC_DEC_INEXACT] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         status <= fct_pkg::STATUS_RESET;
      else
         status <= next_status;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         exc_req <= 1'b0;
         exc_pre <= 1'b0;
         exc_vector <= 8'h00;
         result <= 8'h00;
      end
      else
      begin
         exc_req <= 1'b0;
         exc_pre <= 1'b0;
         if (start)
         begin
            result <= 8'h00;
            result[fct_pkg::RES_BUSY] <= accept;
            result[fct_pkg::RES_DONE] <= !accept;
            result[fct_pkg::RES_REJECT] <= !id_ok || !(is_trap || is_test);
            result[fct_pkg::RES_UNIMP] <= id_ok && unimp;
            result[fct_pkg::RES_EAERR] <= id_ok && is_test && !unimp && !ea_ok;
            if (id_ok && unimp)
            begin
               exc_pre <= 1'b1;
               exc_vector <= UNIMP_VECTOR;
            end
         end
         if (state == fct_pkg::ST_EXEC)
         begin
            result[fct_pkg::RES_BUSY] <= 1'b0;
            result[fct_pkg::RES_DONE] <= 1'b1;
            // An enabled unordered trap pre-empts the instruction, though the result still marks it done and not busy.
            if (exec_trap && unord_trap)
            begin
               exc_pre <= 1'b1;
               exc_vector <= UNORD_VECTOR;
               result[fct_pkg::RES_UNORD] <= 1'b1;
            end
            else if (exec_trap && cond_true)
            begin
               exc_req <= 1'b1;
               exc_vector <= TRAP_VECTOR;
               result[fct_pkg::RES_TRAP] <= 1'b1;
            end
            // A false condition leaves every output quiet.
         end
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence seq_trap_exec;
      exec_trap && !unord_trap;
   endsequence
   sequence seq_bus_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   chk_bus_answer: assert property (seq_bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not after exactly one wait cycle");
   chk_trap_taken: assert property (seq_trap_exec ##0 cond_true |=> exc_req && !exc_pre
      && exc_vector == TRAP_VECTOR)
      else $error("true condition did not raise the trap vector");
   chk_trap_pc: assert property (exc_req |-> next_pc == $past(iaddr) + 32'h0000_0004
      + {28'h0000000, ext_total, 1'b0})
      else $error("stacked address is not the following instruction");
   chk_trap_false: assert property (seq_trap_exec ##0 !cond_true |=> !exc_req && !exc_pre)
      else $error("false condition caused an exception");
   chk_skip_words: assert property (ext_take && !test_q |=> $stable(opnd))
      else $error("trap immediate word disturbed the operand");
   chk_word_order: assert property (ext_take && test_q |=> opnd[15:0] == $past(avs_writedata[15:0])
      && opnd[31:16] == $past(opnd[15:0]))
      else $error("operand words not shifted in order");
   chk_unord_flags: assert property (exec_trap && unord_set |=> status[fct_pkg::EXC_UNORD]
      && status[fct_pkg::ACC_INVALID])
      else $error("unordered flag or accrued invalid bit not set");
   chk_trap_keeps: assert property (exec_trap && !sts_wr |=> status[31:16] == $past(status[31:16])
      && status[14:8] == $past(status[14:8]) && status[6:0] == $past(status[6:0]))
      else $error("trap altered status bits it must keep");
   chk_unord_pre: assert property (exec_trap && unord_trap |=> exc_pre && !exc_req
      && exc_vector == UNORD_VECTOR)
      else $error("enabled unordered case not reported before completion");
   chk_test_codes: assert property (exec_test |=> status[fct_pkg::COND_N] == $past(c_neg)
      && status[fct_pkg::COND_Z] == $past(c_zero) && status[fct_pkg::COND_I] == $past(c_inf)
      && status[fct_pkg::COND_NAN] == $past(c_nan) && status[fct_pkg::EXC_SIGNAN] == $past(c_signan))
      else $error("test condition codes wrong");
   chk_test_clears: assert property (exec_test |=> status[13:9] == 5'h00 && !status[fct_pkg::EXC_UNORD])
      else $error("test left an exception flag set");
   chk_unimp_exc: assert property (start && id_ok && unimp |=> exc_pre && exc_vector == UNIMP_VECTOR
      && state == fct_pkg::ST_IDLE)
      else $error("packed source did not raise unimplemented type");
   chk_foreign_id:
      assert property (start && !id_ok |=> state == fct_pkg::ST_IDLE && result[fct_pkg::RES_REJECT])
      else $error("instruction for another unit was accepted");
endmodule : fct_decoder

// *** core/fct_pred_eval.sv ***
`timescale 1ns/1ps
module fct_pred_eval
(
   input wire logic [4:0] pred,
   input wire logic code_n,
   input wire logic code_z,
   input wire logic code_nan,
   output logic cond_true,
   output logic nonaware
);
   // The upper eight tests of each half are the complements of the lower eight in reverse order.
   function automatic logic fct_base(input logic [2:0] sel, input logic n, input logic z, input logic u);
      case (sel)
         3'h0: fct_base = 1'b0;
         3'h1: fct_base = z;
         3'h2: fct_base = ~(u | z | n);
         3'h3: fct_base = z | ~(u | n);
         3'h4: fct_base = n & ~(u | z);
         3'h5: fct_base = z | (n & ~u);
         3'h6: fct_base = ~(u | z);
         default: fct_base = ~u;
      endcase
   endfunction : fct_base

   always_comb
   begin
      if (pred[3])
         cond_true = ~fct_base(~pred[2:0], code_n, code_z, code_nan);
      else
         cond_true = fct_base(pred[2:0], code_n, code_z, code_nan);
      nonaware = pred[4];
   end
endmodule : fct_pred_eval

// *** shared/fct_pkg.sv ***
package fct_pkg;
   localparam logic [4:0] OFF_WORD0 = 5'h00;
   localparam logic [4:0] OFF_WORD1 = 5'h04;
   localparam logic [4:0] OFF_EXT = 5'h08;
   localparam logic [4:0] OFF_STATUS = 5'h0c;
   localparam logic [4:0] OFF_CTRL = 5'h10;
   localparam logic [4:0] OFF_RESULT = 5'h14;
   localparam logic [4:0] OFF_IADDR = 5'h18;
   localparam logic [4:0] OFF_NEXTPC = 5'h1c;
   localparam int COND_N = 27;
   localparam int COND_Z = 26;
   localparam int COND_I = 25;
   localparam int COND_NAN = 24;
   localparam int EXC_UNORD = 15;
   localparam int EXC_SIGNAN = 14;
   localparam int EXC_OPERAND = 13;
   localparam int EXC_OVERFLOW = 12;
   localparam int EXC_UNDERFLOW = 11;
   localparam int EXC_DIVZERO = 10;
   localparam int EXC_INEXACT = 9;
   localparam int EXC_DEC_INEXACT = 8;
   localparam int ACC_INVALID = 7;
   localparam int CTRL_UNORD_EN = 3;
   localparam int RES_BUSY = 0;
   localparam int RES_DONE = 1;
   localparam int RES_TRAP = 2;
   localparam int RES_UNORD = 3;
   localparam int RES_REJECT = 4;
   localparam int RES_UNIMP = 5;
   localparam int RES_EAERR = 6;
   localparam logic [3:0] CTRL_RESET = 4'h1;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [3:0] OP_LINE = 4'hf;
   localparam logic [2:0] GEN_TYPE = 3'h0;
   localparam logic [2:0] TRAP_TYPE = 3'h1;
   localparam logic [2:0] TRAP_EA = 3'h7;
   localparam logic [2:0] TMODE_WORD = 3'h2;
   localparam logic [2:0] TMODE_LONG = 3'h3;
   localparam logic [2:0] TMODE_NONE = 3'h4;
   localparam logic [6:0] TEST_OPMODE = 7'h3a;

   typedef enum logic [2:0] {
      FMT_L = 3'b000, FMT_S = 3'b001, FMT_X = 3'b010, FMT_P = 3'b011,
      FMT_W = 3'b100, FMT_D = 3'b101, FMT_B = 3'b110
   } fct_fmt_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_COLLECT = 2'b01, ST_EXEC = 2'b10
   } fct_state_type;

   // Count of 16-bit operand words that carry a source of the given format.
   function automatic logic [2:0] fct_fmt_words(input fct_fmt_type fmt);
      case (fmt)
         FMT_B, FMT_W: fct_fmt_words = 3'h1;
         FMT_L, FMT_S: fct_fmt_words = 3'h2;
         FMT_D: fct_fmt_words = 3'h4;
         FMT_X, FMT_P: fct_fmt_words = 3'h6;
         default: fct_fmt_words = 3'h0;
      endcase
   endfunction : fct_fmt_words

   function automatic logic fct_ea_legal(input logic [2:0] mode, input logic [2:0] reg_f, input fct_fmt_type fmt);
      case (mode)
         3'h0: fct_ea_legal = (fmt == FMT_L) || (fmt == FMT_S) || (fmt == FMT_W) || (fmt == FMT_B);
         3'h2, 3'h3, 3'h4, 3'h5, 3'h6: fct_ea_legal = (fmt != 3'h7);
         3'h7: fct_ea_legal = (reg_f <= 3'h4) && (fmt != 3'h7);
         default: fct_ea_legal = 1'b0;
      endcase
   endfunction : fct_ea_legal
endpackage : fct_pkg

// *** tb/fct_cpu_model.sv ***
`timescale 1ns/1ps
// Stands in for the main processor: it only takes exception pulses and remembers them.
module fct_cpu_model
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic exc_req,
   input wire logic exc_pre,
   input wire logic [7:0] exc_vector,
   output int trap_count,
   output int pre_count,
   output logic [7:0] last_vector
);
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trap_count <= 0;
         pre_count <= 0;
         last_vector <= 8'h00;
      end
      else if (exc_req || exc_pre)
      begin
         trap_count <= trap_count + (exc_req ? 1 : 0);
         pre_count <= pre_count + (exc_pre ? 1 : 0);
         last_vector <= exc_vector;
      end
   end
endmodule : fct_cpu_model

// *** tb/fct_decoder_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module fct_decoder_tb_top;
   localparam logic [7:0] VT = 8'h20;
   localparam logic [7:0] VB = 8'h21;
   localparam logic [7:0] VU = 8'h22;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic exc_req;
   logic exc_pre;
   logic [7:0] exc_vector;
   logic [7:0] last_vector;
   logic [31:0] rd;
   logic [31:0] sexp;
   int trap_count;
   int pre_count;
   int bad_count = 0;
   int compares = 0;
   int n_trap = 0;
   int n_pre = 0;
   logic [2:0] tmode [3] = '{3'h4, 3'h2, 3'h3};
   logic [15:0] tw0 [7] = '{16'hf47c, 16'hf208, 16'hf200, 16'hf23d, 16'hf23c, 16'hf200, 16'hf201};
   logic [15:0] tw1 [7] = '{16'h000f, 16'h503a, 16'h543a, 16'h503a, 16'h4c3a, 16'h503b, 16'h003a};
   logic [6:0] tres [7] = '{7'h12, 7'h42, 7'h42, 7'h42, 7'h22, 7'h12, 7'h42};
   logic [31:0] sval [8] = '{32'h3f80_0000, 32'hbf80_0000, 32'h0000_0000, 32'h8000_0000,
      32'h7f80_0000, 32'hff80_0000, 32'h7fc0_0000, 32'h7fa0_0000};
   logic [3:0] scc [8] = '{4'h0, 4'h8, 4'h4, 4'hc, 4'h2, 4'ha, 4'h1, 4'h1};

   always #4 sys_clk = ~sys_clk;

   fct_decoder #(.TRAP_VECTOR(VT), .UNORD_VECTOR(VB), .UNIMP_VECTOR(VU)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .exc_req(exc_req), .exc_pre(exc_pre),
      .exc_vector(exc_vector));
   fct_cpu_model cpu (.sys_clk(sys_clk), .rst_n(rst_n), .exc_req(exc_req), .exc_pre(exc_pre),
      .exc_vector(exc_vector), .trap_count(trap_count), .pre_count(pre_count), .last_vector(last_vector));

   task automatic give_verdict;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   // The request is held until waitrequest is seen low, so any slave latency is accepted.
   task automatic acc(input logic wr_en, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr_en;
      avs_read <= !wr_en;
      do
         @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : acc

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask : wr

   task automatic rdchk(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
      acc(1'b0, a, 32'h0, rd);
      `CHK(rd & m, e)
   endtask : rdchk

   task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] e0, input logic [15:0] e1,
      input int n);
      wr(fct_pkg::OFF_IADDR, 32'h0000_1000);
      wr(fct_pkg::OFF_WORD0, {16'h0000, w0});
      wr(fct_pkg::OFF_WORD1, {16'h0000, w1});
      if (n > 0)
         wr(fct_pkg::OFF_EXT, {16'h0000, e0});
      if (n > 1)
         wr(fct_pkg::OFF_EXT, {16'h0000, e1});
      for (int i = 0; i < 40; i++)
      begin
         acc(1'b0, fct_pkg::OFF_RESULT, 32'h0, rd);
         if (rd[fct_pkg::RES_DONE] === 1'b1)
            break;
      end
      if (rd[fct_pkg::RES_DONE] !== 1'b1)
         bad_count++;
   endtask : run

   // The extra read lets the model's pulse counters settle before they are compared.
   task automatic res_chk(input logic [6:0] e, input logic [6:0] m, input int ntr, input int npr,
      input logic [7:0] vec);
      acc(1'b0, fct_pkg::OFF_RESULT, 32'h0, rd);
      `CHK(rd[6:0] & m, e)
      n_trap += ntr;
      n_pre += npr;
      `CHK(trap_count, n_trap)
      `CHK(pre_count, n_pre)
      if (ntr + npr > 0)
         `CHK(last_vector, vec)
   endtask : res_chk

   initial
   begin
      #300us;
      bad_count++;
      give_verdict();
   end

   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      `CHK(avs_waitrequest, 1'b1)
      rdchk(fct_pkg::OFF_CTRL, 32'h0000_0001, 32'hffff_ffff);
      rdchk(fct_pkg::OFF_STATUS, 32'h0000_0000, 32'hffff_ffff);
      rdchk(5'h02, 32'h0000_0000, 32'hffff_ffff);
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         run({13'h1e4f, tmode[i % 3]}, (i < 3) ? 16'h000f : 16'h0000, 16'h1234, 16'h5678, i % 3);
         res_chk((i < 3) ? 7'h06 : 7'h02, 7'h7f, (i < 3) ? 1 : 0, 0, VT);
         rdchk(fct_pkg::OFF_NEXTPC, 32'h0000_1004 + 32'(2 * (i % 3)), 32'hffff_ffff);
         rdchk(fct_pkg::OFF_STATUS, 32'h0000_0000, 32'hffff_ffff);
      end
      $display("test trap forms done");
      wr(fct_pkg::OFF_STATUS, 32'h0100_0000);
      run(16'hf27c, 16'h001f, 16'h0000, 16'h0000, 0);
      res_chk(7'h06, 7'h06, 1, 0, VT);
      rdchk(fct_pkg::OFF_STATUS, 32'h0100_8080, 32'hffff_ffff);
      wr(fct_pkg::OFF_STATUS, 32'h0100_0000);
      run(16'hf27c, 16'h000f, 16'h0000, 16'h0000, 0);
      res_chk(7'h06, 7'h0e, 1, 0, VT);
      rdchk(fct_pkg::OFF_STATUS, 32'h0100_0000, 32'hffff_ffff);
      wr(fct_pkg::OFF_CTRL, 32'h0000_0009);
      run(16'hf27c, 16'h001f, 16'h0000, 16'h0000, 0);
      res_chk(7'h08, 7'h0c, 0, 1, VB);
      wr(fct_pkg::OFF_STATUS, 32'h0000_0000);
      run(16'hf27c, 16'h001f, 16'h0000, 16'h0000, 0);
      res_chk(7'h04, 7'h0c, 1, 0, VT);
      wr(fct_pkg::OFF_CTRL, 32'h0000_0001);
      $display("test unordered done");
      for (int i = 0; i < 8; i++)
      begin
         wr(fct_pkg::OFF_STATUS, 32'h02ab_ff00);
         run(16'hf200, 16'h45ba, sval[i][31:16], sval[i][15:0], 2);
         res_chk(7'h02, 7'h7f, 0, 0, VT);
         sexp = {4'h0, scc[i], 8'hab, ((i == 7) ? 8'h40 : 8'h00), 8'h00};
         rdchk(fct_pkg::OFF_STATUS, sexp, 32'hffff_ff00);
      end
      run(16'hf23c, 16'h51ba, 16'h0000, 16'h0000, 1);
      res_chk(7'h02, 7'h7f, 0, 0, VT);
      rdchk(fct_pkg::OFF_STATUS, 32'h04ab_0000, 32'hffff_ff00);
      $display("test operand classes done");
      for (int i = 0; i < 7; i++)
      begin
         run(tw0[i], tw1[i], 16'h0000, 16'h0000, 1);
         res_chk(tres[i], 7'h7f, 0, (i == 4) ? 1 : 0, VU);
      end
      $display("test refusals done");
      give_verdict();
   end
endmodule : fct_decoder_tb_top
